//--- hw/idb_top.sv
// Identify parameter block builder with APB configuration and word stream
//
// How it works
// - Block leaves as one sector of words over the read-sector data-in handshake.
// - Reserved bits and words, and words not modelled, read as zero.
// - Word 91, power management level, is always zero.
// - Word 255 holds checksum in high byte, signature in low byte.
// - Word 217 is one, marking a non-rotating medium.
// - Words 100 to 103 carry the 48-bit maximum user address.
// - Words 89 and 90 carry the erase and enhanced erase times.
// - Word 93 carries the hardware reset result.
// - Word 0 holds the fixed general configuration value.
// - Words 7 and 8 hold the sector count, high word first.
// - Serial field is right-justified and padded with spaces.
// - Right ten serial bytes factory id, left ten user value.
// - Word 47 says one sector per interrupt at most.
// - Word 49 clears bit 13, sets IORDY bit 11 and address bit 9.
// - Word 51 reports PIO mode 2.
// - Word 53 sets validity bits 0, 1 and 2.
// - Words 57 and 58 are cylinders times heads times sectors.
// - High byte of word 59 is always the validity value.
// - Low byte of word 59 follows the set-multiple count, zero at reset.
// - Words 60 and 61 carry the sectors addressable by block address.
// - Word 63 selects at most one of modes 2, 1 and 0.
// - Word 63 supports modes 0, 1 and 2 together.
// - Word 64 flags PIO modes 3 and 4, upper bits zero.
`timescale 1ns/100ps
`default_nettype none
`include "idb_consts.svh"
module idb_top
    import idb_pkg::*;
#(
    parameter logic [79:0] FACTORY_ID = 80'h41424344454647484950
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic start_identify,
    output logic [15:0] data_word,
    output logic data_req,
    input wire logic data_ack,
    output logic busy
);
    // FACTORY_ID value above is arbitrary

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic [15:0] def_cyl;
    logic [15:0] def_head;
    logic [15:0] def_spt;
    logic [31:0] total_sectors;
    logic [15:0] cur_cyl;
    logic [15:0] cur_head;
    logic [15:0] cur_spt;
    logic [31:0] lba28_sectors;
    logic [63:0] lba48_max;
    logic [7:0] multi_count;
    logic [1:0] dma_sel;
    logic [31:0] erase_times;
    logic [15:0] hwreset_result;
    logic [79:0] user_serial;
    logic [7:0] last_csum;

    idb_state_e state;
    idb_waddr_t idx;
    logic [7:0] csum_sum;
    idb_word_t gen_word;
    logic [31:0] cur_capacity;
    logic [159:0] serial_bytes;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic wr_acc;
    logic go;

    idb_buf_if buf_bus ();

    idb_word_mem #(.DEPTH(256)) u_mem (
        .clk(clk),
        .bus(buf_bus)
    );

    idb_csum u_csum (
        .clk(clk),
        .clr(state == IDB_IDLE),
        .add(state == IDB_FILL),
        .word(gen_word),
        .sum(csum_sum)
    );

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Access phase always takes two cycles; ready is a flop so it must lag
    assign wr_acc = psel & penable & pwrite & pready;

    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `IDB_REG_CTRL: rd_mux = {30'h0, data_req, busy};
            `IDB_REG_DEF_CYL: rd_mux = {16'h0, def_cyl};
            `IDB_REG_DEF_HEAD: rd_mux = {16'h0, def_head};
            `IDB_REG_DEF_SPT: rd_mux = {16'h0, def_spt};
            `IDB_REG_TOTAL: rd_mux = total_sectors;
            `IDB_REG_CUR_CYL: rd_mux = {16'h0, cur_cyl};
            `IDB_REG_CUR_HEAD: rd_mux = {16'h0, cur_head};
            `IDB_REG_CUR_SPT: rd_mux = {16'h0, cur_spt};
            `IDB_REG_LBA28: rd_mux = lba28_sectors;
            `IDB_REG_LBA48_LO: rd_mux = lba48_max[31:0];
            `IDB_REG_LBA48_HI: rd_mux = lba48_max[63:32];
            `IDB_REG_MULTI: rd_mux = {24'h0, multi_count};
            `IDB_REG_DMA_SEL: rd_mux = {30'h0, dma_sel};
            `IDB_REG_ERASE: rd_mux = erase_times;
            `IDB_REG_HWRESET: rd_mux = {16'h0, hwreset_result};
            `IDB_REG_SER0: rd_mux = user_serial[79:48];
            `IDB_REG_SER1: rd_mux = user_serial[47:16];
            `IDB_REG_SER2: rd_mux = {16'h0, user_serial[15:0]};
            `IDB_REG_STATUS: rd_mux = {16'h0, last_csum, idx};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & penable & ~pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~rd_hit;
        end else begin
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            def_cyl <= 16'h0000;
            def_head <= 16'h0000;
            def_spt <= 16'h0000;
            total_sectors <= 32'h0000_0000;
            cur_cyl <= 16'h0000;
            cur_head <= 16'h0000;
            cur_spt <= 16'h0000;
            lba28_sectors <= 32'h0000_0000;
            lba48_max <= 64'h0;
            erase_times <= 32'h0000_0000;
            hwreset_result <= 16'h0000;
        end else if (wr_acc) begin
            unique case (paddr)
                `IDB_REG_DEF_CYL: def_cyl <= pwdata[15:0];
                `IDB_REG_DEF_HEAD: def_head <= pwdata[15:0];
                `IDB_REG_DEF_SPT: def_spt <= pwdata[15:0];
                `IDB_REG_TOTAL: total_sectors <= pwdata;
                `IDB_REG_CUR_CYL: cur_cyl <= pwdata[15:0];
                `IDB_REG_CUR_HEAD: cur_head <= pwdata[15:0];
                `IDB_REG_CUR_SPT: cur_spt <= pwdata[15:0];
                `IDB_REG_LBA28: lba28_sectors <= pwdata;
                `IDB_REG_LBA48_LO: lba48_max[31:0] <= pwdata;
                `IDB_REG_LBA48_HI: lba48_max[63:32] <= pwdata;
                `IDB_REG_ERASE: erase_times <= pwdata;
                `IDB_REG_HWRESET: hwreset_result <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            multi_count <= `IDB_RST_MULTI;
        end else if (wr_acc && paddr == `IDB_REG_MULTI) begin
            multi_count <= pwdata[7:0];
        end
    end

    // one selection code, so two modes can never show at once
    always_ff @(posedge clk) begin
        if (rst) begin
            dma_sel <= `IDB_RST_DMA_SEL;
        end else if (wr_acc && paddr == `IDB_REG_DMA_SEL) begin
            dma_sel <= pwdata[1:0];
        end
    end

    // user half of serial defaults to ten zero characters
    always_ff @(posedge clk) begin
        if (rst) begin
            user_serial <= `IDB_RST_USER_SER;
        end else if (wr_acc) begin
            if (paddr == `IDB_REG_SER0) begin
                user_serial[79:48] <= pwdata;
            end
            if (paddr == `IDB_REG_SER1) begin
                user_serial[47:16] <= pwdata;
            end
            if (paddr == `IDB_REG_SER2) begin
                user_serial[15:0] <= pwdata[15:0];
            end
        end
    end

    // ----------------------------------------
    // Word generator
    // ----------------------------------------
    // capacity from current geometry, truncated to 32 bits
    assign cur_capacity = 32'(cur_cyl * cur_head * cur_spt);

    // null bytes are taken as padding and shown as spaces
    always_comb begin
        serial_bytes = {user_serial, FACTORY_ID};
        for (int b = 0; b < 20; b++) begin
            if (serial_bytes[b*8 +: 8] == 8'h00) begin
                serial_bytes[b*8 +: 8] = `IDB_V_SPACE;
            end
        end
    end

    always_comb begin
        gen_word = 16'h0000;
        unique case (idx)
            `IDB_W_GENCFG: gen_word = `IDB_V_GENCFG;
            `IDB_W_DEF_CYL: gen_word = def_cyl;
            `IDB_W_DEF_HEAD: gen_word = def_head;
            `IDB_W_DEF_SPT: gen_word = def_spt;
            `IDB_W_TOTAL_MSW: gen_word = total_sectors[31:16];
            `IDB_W_TOTAL_LSW: gen_word = total_sectors[15:0];
            `IDB_W_MULTI_MAX: gen_word = `IDB_V_MULTI_MAX;
            `IDB_W_CAPAB: gen_word = `IDB_V_CAPAB;
            `IDB_W_PIO_MODE: gen_word = `IDB_V_PIO_MODE;
            `IDB_W_VALID: gen_word = `IDB_V_VALID;
            `IDB_W_CUR_CYL: gen_word = cur_cyl;
            `IDB_W_CUR_HEAD: gen_word = cur_head;
            `IDB_W_CUR_SPT: gen_word = cur_spt;
            `IDB_W_CAP_LSW: gen_word = cur_capacity[15:0];
            `IDB_W_CAP_MSW: gen_word = cur_capacity[31:16];
            `IDB_W_MULTI_SET: gen_word = {`IDB_V_MULTI_VALID, multi_count};
            `IDB_W_LBA28_LSW: gen_word = lba28_sectors[15:0];
            `IDB_W_LBA28_MSW: gen_word = lba28_sectors[31:16];
            // modes 0 to 2 supported together
            `IDB_W_MWDMA: begin
                gen_word = {13'h0, `IDB_V_MWDMA_SUP};
                if (dma_sel != 2'h0) begin
                    gen_word[8 + dma_sel - 2'h1] = 1'b1;
                end
            end
            `IDB_W_ADV_PIO: gen_word = `IDB_V_ADV_PIO;
            `IDB_W_MAJOR: gen_word = `IDB_V_MAJOR;
            `IDB_W_MINOR: gen_word = `IDB_V_MINOR;
            `IDB_W_UDMA: gen_word = `IDB_V_UDMA;
            `IDB_W_ERASE: gen_word = erase_times[15:0];
            `IDB_W_ERASE_ENH: gen_word = erase_times[31:16];
            `IDB_W_APM: gen_word = `IDB_V_APM;
            `IDB_W_HWRESET: gen_word = hwreset_result;
            // 48-bit maximum address, low word first
            `IDB_W_LBA48_0: gen_word = lba48_max[15:0];
            `IDB_W_LBA48_1: gen_word = lba48_max[31:16];
            `IDB_W_LBA48_2: gen_word = lba48_max[47:32];
            `IDB_W_LBA48_3: gen_word = lba48_max[63:48];
            `IDB_W_ROTATION: gen_word = `IDB_V_ROTATION;
            default: begin
                if (idx >= `IDB_W_CYC_FIRST && idx <= `IDB_W_CYC_LAST) begin
                    gen_word = `IDB_V_CYCLE;
                end else if (idx >= `IDB_W_SER_FIRST && idx <= `IDB_W_SER_LAST) begin
                    // First character of each pair goes in the high byte
                    gen_word = serial_bytes[(8'd9 - (idx - `IDB_W_SER_FIRST)) * 16 +: 16];
                end
            end
        endcase
    end

    // ----------------------------------------
    // Build and send sequence
    // ----------------------------------------
    assign go = start_identify | (wr_acc && paddr == `IDB_REG_CTRL && pwdata[0]);

    always_comb begin
        buf_bus.we = 1'b0;
        buf_bus.waddr = idx;
        buf_bus.wdata = gen_word;
        buf_bus.re = (state == IDB_READ);
        buf_bus.raddr = idx;
        if (state == IDB_FILL) begin
            buf_bus.we = 1'b1;
        end else if (state == IDB_SEAL) begin
            buf_bus.we = 1'b1;
            buf_bus.waddr = `IDB_W_INTEGRITY;
            // negate the body sum plus the signature
            buf_bus.wdata = {8'(8'h00 - csum_sum - `IDB_V_SIGNATURE), `IDB_V_SIGNATURE};
        end
    end

    // whole block is built first, then handed out word by word
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= IDB_IDLE;
            idx <= 8'h00;
            busy <= 1'b0;
            data_req <= 1'b0;
            data_word <= 16'h0000;
        end else begin
            unique case (state)
                IDB_IDLE: begin
                    if (go) begin
                        state <= IDB_FILL;
                        idx <= 8'h00;
                        busy <= 1'b1;
                    end
                end
                IDB_FILL: begin
                    if (idx == `IDB_W_LAST_BODY) begin
                        state <= IDB_SEAL;
                    end else begin
                        idx <= idx + 8'h01;
                    end
                end
                IDB_SEAL: begin
                    state <= IDB_READ;
                    idx <= 8'h00;
                end
                IDB_READ: state <= IDB_WAIT;
                IDB_WAIT: begin
                    data_word <= buf_bus.rdata;
                    data_req <= 1'b1;
                    state <= IDB_HOLD;
                end
                IDB_HOLD: begin
                    // word stands until the host takes it
                    if (data_ack) begin
                        data_req <= 1'b0;
                        idx <= idx + 8'h01;
                        if (idx == `IDB_W_INTEGRITY) begin
                            state <= IDB_IDLE;
                            busy <= 1'b0;
                        end else begin
                            state <= IDB_READ;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            last_csum <= 8'h00;
        end else if (state == IDB_SEAL) begin
            last_csum <= 8'(8'h00 - csum_sum - `IDB_V_SIGNATURE);
        end
    end
endmodule
`default_nettype wire

//--- hw/idb_consts.svh
// Offsets, word addresses, fixed words and reset values of the identify data builder
`ifndef IDB_CONSTS_SVH
`define IDB_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IDB_REG_CTRL       8'h00
`define IDB_REG_DEF_CYL    8'h04
`define IDB_REG_DEF_HEAD   8'h08
`define IDB_REG_DEF_SPT    8'h0c
`define IDB_REG_TOTAL      8'h10
`define IDB_REG_CUR_CYL    8'h14
`define IDB_REG_CUR_HEAD   8'h18
`define IDB_REG_CUR_SPT    8'h1c
`define IDB_REG_LBA28      8'h20
`define IDB_REG_LBA48_LO   8'h24
`define IDB_REG_LBA48_HI   8'h28
`define IDB_REG_MULTI      8'h2c
`define IDB_REG_DMA_SEL    8'h30
`define IDB_REG_ERASE      8'h34
`define IDB_REG_HWRESET    8'h38
`define IDB_REG_SER0       8'h3c
`define IDB_REG_SER1       8'h40
`define IDB_REG_SER2       8'h44
`define IDB_REG_STATUS     8'h48

// ----------------------------------------
// Word addresses inside the block
// ----------------------------------------
`define IDB_W_GENCFG       8'd0
`define IDB_W_DEF_CYL      8'd1
`define IDB_W_DEF_HEAD     8'd3
`define IDB_W_DEF_SPT      8'd6
`define IDB_W_TOTAL_MSW    8'd7
`define IDB_W_TOTAL_LSW    8'd8
`define IDB_W_SER_FIRST    8'd10
`define IDB_W_SER_LAST     8'd19
`define IDB_W_MULTI_MAX    8'd47
`define IDB_W_CAPAB        8'd49
`define IDB_W_PIO_MODE     8'd51
`define IDB_W_VALID        8'd53
`define IDB_W_CUR_CYL      8'd54
`define IDB_W_CUR_HEAD     8'd55
`define IDB_W_CUR_SPT      8'd56
`define IDB_W_CAP_LSW      8'd57
`define IDB_W_CAP_MSW      8'd58
`define IDB_W_MULTI_SET    8'd59
`define IDB_W_LBA28_LSW    8'd60
`define IDB_W_LBA28_MSW    8'd61
`define IDB_W_MWDMA        8'd63
`define IDB_W_ADV_PIO      8'd64
`define IDB_W_CYC_FIRST    8'd65
`define IDB_W_CYC_LAST     8'd68
`define IDB_W_MAJOR        8'd80
`define IDB_W_MINOR        8'd81
`define IDB_W_UDMA         8'd88
`define IDB_W_ERASE        8'd89
`define IDB_W_ERASE_ENH    8'd90
`define IDB_W_APM          8'd91
`define IDB_W_HWRESET      8'd93
`define IDB_W_LBA48_0      8'd100
`define IDB_W_LBA48_1      8'd101
`define IDB_W_LBA48_2      8'd102
`define IDB_W_LBA48_3      8'd103
`define IDB_W_ROTATION     8'd217
`define IDB_W_LAST_BODY    8'd254
`define IDB_W_INTEGRITY    8'd255

// ----------------------------------------
// Fixed word values
// ----------------------------------------
`define IDB_V_GENCFG       16'h044a
`define IDB_V_MULTI_MAX    16'h8001
`define IDB_V_CAPAB        16'h0b00
`define IDB_V_PIO_MODE     16'h0200
`define IDB_V_VALID        16'h0007
`define IDB_V_MULTI_VALID  8'h01
`define IDB_V_MWDMA_SUP    3'h7
`define IDB_V_ADV_PIO      16'h0003
`define IDB_V_CYCLE        16'h0078
`define IDB_V_MAJOR        16'h00fe
`define IDB_V_MINOR        16'h0021
`define IDB_V_UDMA         16'h007f
`define IDB_V_APM          16'h0000
`define IDB_V_ROTATION     16'h0001
`define IDB_V_SIGNATURE    8'ha5
`define IDB_V_SPACE        8'h20
`define IDB_V_DIGIT_ZERO   8'h30

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IDB_RST_USER_SER   80'h30303030303030303030
`define IDB_RST_MULTI      8'h00
`define IDB_RST_DMA_SEL    2'h0

`endif

//--- hw/idb_pkg.sv
// Types shared by the identify data builder
package idb_pkg;
    typedef enum logic [2:0] {
        IDB_IDLE,
        IDB_FILL,
        IDB_SEAL,
        IDB_READ,
        IDB_WAIT,
        IDB_HOLD
    } idb_state_e;

    typedef logic [7:0] idb_waddr_t;
    typedef logic [15:0] idb_word_t;
endpackage

//--- hw/idb_buf_if.sv
// Write and read ports of the parameter block buffer
`timescale 1ns/100ps
`default_nettype none
interface idb_buf_if;
    import idb_pkg::*;
    logic we;
    idb_waddr_t waddr;
    idb_word_t wdata;
    logic re;
    idb_waddr_t raddr;
    idb_word_t rdata;
    modport builder (output we, output waddr, output wdata, output re, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface
`default_nettype wire

//--- hw/idb_word_mem.sv
// 256-word buffer holding one parameter block, registered read
`timescale 1ns/100ps
`default_nettype none
module idb_word_mem
    import idb_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input wire logic clk,
    idb_buf_if.mem bus
);
    idb_word_t store [DEPTH];

    always_ff @(posedge clk) begin
        if (bus.we) begin
            store[bus.waddr] <= bus.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (bus.re) begin
            bus.rdata <= store[bus.raddr];
        end
    end
endmodule
`default_nettype wire

//--- hw/idb_csum.sv
// Running byte sum of the words written into the block
`timescale 1ns/100ps
`default_nettype none
module idb_csum
    import idb_pkg::*;
(
    input wire logic clk,
    input wire logic clr,
    input wire logic add,
    input wire idb_word_t word,
    output logic [7:0] sum
);
    always_ff @(posedge clk) begin
        if (clr) begin
            sum <= 8'h00;
        end else if (add) begin
            sum <= 8'(sum + word[15:8] + word[7:0]);
        end
    end
endmodule
`default_nettype wire

//--- tb/idb_checker.sv
// Assertions on the ports of the identify data builder
`timescale 1ns/100ps
`default_nettype none
module idb_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic start_identify,
    input wire logic [15:0] data_word,
    input wire logic data_req,
    input wire logic data_ack,
    input wire logic busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic [8:0] acks;
    // Words taken so far in the current build, cleared while idle
    always_ff @(posedge clk) begin
        if (rst || !busy) begin
            acks <= 9'h000;
        end else if (data_req && data_ack) begin
            acks <= acks + 9'h001;
        end
    end
    apb_wait_a: assert property (psel && penable && !pready |-> ##1 pready)
        else $error("pready late");
    apb_pulse_a: assert property (pready |-> $past(psel && penable) ##1 !pready)
        else $error("pready not a single access pulse");
    apb_err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
        else $error("refused read not zero");
    word_hold_a: assert property (data_req && !data_ack |=> data_req && $stable(data_word))
        else $error("word dropped before ack");
    word_gap_a: assert property (data_req && data_ack |=> !data_req [*2] ##1 (data_req || !busy))
        else $error("next word spacing wrong");
    first_word_a: assert property (start_identify && !busy |-> ##[258:261] data_req)
        else $error("first word late");
    apm_zero_a: assert property (data_req && acks == 9'd91 |-> data_word == 16'h0000)
        else $error("word 91 not zero");
    seal_sig_a: assert property (data_req && acks == 9'd255 |-> data_word[7:0] == 8'ha5)
        else $error("signature byte wrong");
    rotation_a: assert property (data_req && acks == 9'd217 |-> data_word == 16'h0001)
        else $error("rotation word wrong");
    multi_valid_a: assert property (data_req && acks == 9'd59 |-> data_word[15:8] == 8'h01)
        else $error("word 59 validity byte wrong");
    cover property (pready && pslverr);
    cover property (start_identify && busy);
    cover property (data_req && data_ack && acks == 9'd255);
endmodule
`default_nettype wire

//--- tb/idb_host_model.sv
// Host side model that reads the parameter block word by word
`timescale 1ns/100ps
`default_nettype none
module idb_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic [3:0] slow,
    input wire logic data_req,
    input wire logic [15:0] data_word,
    output logic data_ack,
    output logic [8:0] count
);
    logic [15:0] words [256];
    logic [3:0] dly;
    // data-in handshake, word taken at the ack edge
    always_ff @(posedge clk) begin
        if (rst || clr) begin
            count <= 9'h000;
            data_ack <= 1'b0;
            dly <= 4'h0;
        end else if (data_req && data_ack) begin
            words[count[7:0]] <= data_word;
            count <= count + 9'h001;
            data_ack <= 1'b0;
        end else if (data_req) begin
            // Stall a few cycles to exercise a slow reader
            data_ack <= (dly >= slow);
            dly <= (dly >= slow) ? 4'h0 : dly + 4'h1;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking testbench of the identify data builder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import idb_pkg::*;
    // Factory id value is arbitrary; leading zero bytes test padding
    localparam logic [79:0] FID = 80'h00003132333435363738;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, start_identify = 0, clr = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, r, cfg [19];
    logic pready, pslverr, data_req, data_ack, busy, e;
    logic [15:0] data_word;
    logic [3:0] slow = 4'h0;
    logic [8:0] count;
    idb_word_t exp [256];
    int errors = 0;
    int num_checks = 0;
    always #50 clk = ~clk;
    idb_top #(.FACTORY_ID(FID)) dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .start_identify, .data_word, .data_req, .data_ack, .busy);
    idb_host_model host_u (.clk, .rst, .clr, .slow, .data_req, .data_word, .data_ack, .count);
    task automatic wrap_up();
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic tmo();
        $display("Error at %0t: wait timed out", $time);
        errors++;
        wrap_up();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic cw(input int k);
        chk({16'h0000, host_u.words[k]}, {16'h0000, exp[k]});
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) tmo();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [7:0] sp(input logic [7:0] b);
        return (b == 8'h00) ? 8'h20 : b;
    endfunction
    task automatic exp_block();
        logic [159:0] s;
        logic [47:0] p;
        logic [7:0] sum;
        s = {cfg[15], cfg[16], cfg[17][15:0], FID};
        p = cfg[5][15:0] * cfg[6][15:0] * cfg[7][15:0];
        foreach (exp[i]) exp[i] = 16'h0000;
        for (int i = 0; i < 10; i++) exp[10 + i] = {sp(s[159 - 16 * i -: 8]), sp(s[151 - 16 * i -: 8])};
        {exp[0], exp[1], exp[3], exp[6]} = {16'h044a, cfg[1][15:0], cfg[2][15:0], cfg[3][15:0]};
        {exp[7], exp[8], exp[47], exp[49]} = {cfg[4], 16'h8001, 16'h0b00};
        {exp[51], exp[53], exp[54], exp[55]} = {16'h0200, 16'h0007, cfg[5][15:0], cfg[6][15:0]};
        {exp[56], exp[58], exp[57], exp[59]} = {cfg[7][15:0], p[31:0], 8'h01, cfg[11][7:0]};
        {exp[61], exp[60], exp[64], exp[88]} = {cfg[8], 16'h0003, 16'h007f};
        exp[63] = (cfg[12] == 32'h0) ? 16'h0007 : 16'h0007 | (16'h0080 << cfg[12][1:0]);
        {exp[65], exp[66], exp[67], exp[68]} = {4{16'h0078}};
        {exp[80], exp[81], exp[90], exp[89]} = {16'h00fe, 16'h0021, cfg[13]};
        {exp[93], exp[101], exp[100], exp[103], exp[102]} = {cfg[14][15:0], cfg[9], cfg[10]};
        exp[217] = 16'h0001;
        sum = 8'ha5;
        for (int i = 0; i < 255; i++) sum = sum + exp[i][15:8] + exp[i][7:0];
        exp[255] = {8'h00 - sum, 8'ha5};
    endtask
    // ----------------------------------------
    // One block read, with a go while busy
    // ----------------------------------------
    task automatic build(input logic [3:0] st);
        int n;
        slow <= st;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        if (st[1]) begin
            apb(1'b1, 8'h00, 32'h00000001);
        end else begin
            start_identify <= 1'b1;
            @(posedge clk);
            start_identify <= 1'b0;
        end
        repeat (300) @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        chk({31'h0, r[0]}, 32'h1);
        start_identify <= 1'b1;
        @(posedge clk);
        start_identify <= 1'b0;
        for (n = 0; busy !== 1'b0; n++) begin
            if (n > 20000) tmo();
            @(posedge clk);
        end
        exp_block();
        chk({23'h0, count}, 32'h100);
        for (int k = 0; k < 256; k++) cw(k);
        for (int k = 10; k < 20; k++) cw(k);
        cw(91);
        cw(255);
        cw(217);
        cw(47);
        cw(49);
        cw(51);
        cw(53);
        cw(57);
        cw(59);
        cw(60);
        cw(63);
        cw(64);
        apb(1'b0, 8'h48, 32'h0);
        chk({24'h0, r[15:8]}, {24'h0, exp[255][15:8]});
    endtask
    initial begin
        foreach (cfg[i]) cfg[i] = 32'h00000000;
        {cfg[15], cfg[16], cfg[17]} = {32'h30303030, 32'h30303030, 32'h00003030};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 19; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(r, cfg[i]);
        end
        apb(1'b1, 8'h4c, 32'hffffffff);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 8'h4c, 32'h0);
        chk(r, 32'h0);
        build(4'h0);
        for (int i = 1; i < 15; i++) cfg[i] = {8'(i), 8'h5a, 8'(i + 16), 8'(3 * i)};
        cfg[15] = 32'h00004142;
        for (int s = 0; s < 4; s++) begin
            cfg[12] = 32'(s);
            for (int i = 1; i < 18; i++) apb(1'b1, 8'(4 * i), cfg[i]);
            build(4'(s + 1));
        end
        wrap_up();
    end
endmodule
bind idb_top idb_checker chk_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .start_identify, .data_word, .data_req, .data_ack, .busy);
`default_nettype wire
